/* File: logic/sau_defs.vh */
// Field positions, codes and reset values for the serial-port UART
`ifndef SAU_DEFS_VH
`define SAU_DEFS_VH
`define SAU_WORD_BITS 16
`define SAU_OP_WCFG 2'b11
`define SAU_OP_RCFG 2'b01
`define SAU_OP_WDAT 2'b10
`define SAU_OP_RDAT 2'b00
`define SAU_CFG_RX_QUEUE_ENABLE_N 13
`define SAU_CFG_SW_POWERDOWN 12
`define SAU_CFG_TX_DONE_MASK 11
`define SAU_CFG_RX_DATA_MASK 10
`define SAU_CFG_PARITY_IRQ_MASK 9
`define SAU_CFG_ACT_MASK 8
`define SAU_CFG_INFRARED 7
`define SAU_CFG_ST 6
`define SAU_CFG_PARITY_ENABLE 5
`define SAU_CFG_L 4
`define SAU_CFG_RESET 14'h0000
`define SAU_WD_TE 10
`define SAU_WD_RTS 9
`define SAU_WD_PARITY 8
`define SAU_FIFO_DEPTH 8
`define SAU_OVS 16
`define SAU_VOTE_A 4'h6
`define SAU_VOTE_B 4'h7
`define SAU_VOTE_C 4'h8
`define SAU_VOTE_DONE 4'h9
`define SAU_INFRARED_PULSE 4'h3
`endif

/* File: logic/sau_uart.v */
// Serial-port UART core: host port, baud generator, transmitter, receiver, FIFO
`timescale 1ns/10ps
`include "sau_defs.vh"

// Summary of operation
// - Serial data output tri-stated while chip select is high.
// - Interrupt, transmit and handshake outputs always driven.
// - Hardware powerdown low stops baud clock, transmitter and receiver at once, abandoning transmit; host port keeps running.
// - Inverted clear-to-send pin level is reported in read-data status.
// - Request-to-send pin is driven to the inverse of the bit written in data-write word.
// - In powerdown any receive-line transition raises interrupt when the activity mask is set.
// - Configuration word sets baud, length, parity, FIFO enable.
// - Configuration also sets infrared timing, powerdown, four masks.
// - Data-write word low 7 or 8 bits are the character.
// - Data-write word carries parity bit sent when enabled.
// - Received word interrupts when received-data mask set, or when parity mask set and its parity bit is high.
// - Data read returns oldest character, parity and clear-to-send.
// - One read bit is framing error, or activity in powerdown.
// - Baud clock divides oscillator by divisor from four bits.
// - Baud clock runs at sixteen times bit rate.
// - Transmitter adds start and stop bits at bit rate.
// - Receiver starts a character at a falling receive edge.
// - Start detection may lag the edge by one sample.
// - Start bit value is majority of samples seven to nine.
// - All later bits also resolved by three-sample majority.
// - Eight-word receive FIFO flushed on overflow.
// - Output changes on falling clock, input captured on rising.
// - Transfers are 16 bits; early chip-select rise writes nothing.
// - First two bits select one of four operations.
// - Configuration write clears FIFO, flags and holding registers.
module sau_uart (
	input wire mclk,
	input wire rst_n,
	input wire hw_powerdown_n,
	input wire sclk,
	input wire cs_n,
	input wire din,
	output reg dout,
	output reg dout_oe,
	output reg irq_n,
	output reg tx,
	output reg rts_n,
	input wire cts_n,
	input wire rx
);

	// ----------------------------------------
	// Decoders
	// ----------------------------------------
	function [15:0] baud_divisor;
		input [3:0] sel;
		begin
			baud_divisor = 16'h0001 << sel[3:0];
		end
	endfunction

	function maj3;
		input a;
		input b;
		input c;
		begin
			maj3 = (a & b) | (a & c) | (b & c);
		end
	endfunction

	localparam TX_IDLE = 4'b0001;
	localparam TX_START = 4'b0010;
	localparam TX_DATA = 4'b0100;
	localparam TX_STOP = 4'b1000;
	localparam RX_IDLE = 3'b001;
	localparam RX_BITS = 3'b010;
	localparam RX_STOP = 3'b100;

	reg [13:0] cfg_r;
	reg [13:0] cfg_pend_r;
	reg cfg_pend_v_r;
	reg sclk_d_r;
	reg cs_d_r;
	reg [15:0] sh_in_r;
	reg [15:0] sh_out_r;
	reg [4:0] bcnt_r;
	reg [15:0] div_cnt_r;
	reg tick_r;
	reg [3:0] tx_st_r;
	reg [3:0] tx_ovs_r;
	reg [3:0] tx_idx_r;
	reg [9:0] tx_sh_r;
	reg [8:0] tx_buf_r;
	reg tx_buf_v_r;
	reg t_flag_r;
	reg tx_done_ev_r;
	reg [2:0] rx_st_r;
	reg [3:0] rx_ovs_r;
	reg [3:0] rx_idx_r;
	reg [2:0] rx_smp_r;
	reg [8:0] rx_sh_r;
	reg rx_d_r;
	reg [9:0] fifo_r [0:`SAU_FIFO_DEPTH-1];
	reg [2:0] wp_r;
	reg [2:0] rp_r;
	reg [3:0] cnt_r;
	reg act_r;
	reg par_ev_r;

	wire sclk_rise = sclk & ~sclk_d_r;
	wire sclk_fall = ~sclk & sclk_d_r;
	wire cs_rise = cs_n & ~cs_d_r;
	wire word_ok = (bcnt_r == 5'd16);
	wire [1:0] op = sh_in_r[15:14];
	wire pd = ~hw_powerdown_n | cfg_r[`SAU_CFG_SW_POWERDOWN];
	wire len7 = cfg_r[`SAU_CFG_L];
	wire par_en = cfg_r[`SAU_CFG_PARITY_ENABLE];
	wire [3:0] nbits = (len7 ? 4'd7 : 4'd8) + {3'b000, par_en};
	wire r_flag = (cnt_r != 4'd0);
	wire [9:0] head = r_flag ? fifo_r[rp_r] : 10'h000;
	wire [15:0] rd_word = {r_flag, t_flag_r, 3'b000, pd ? act_r : head[9], ~cts_n,
		head[8:0]};
	wire [15:0] rc_word = {r_flag, t_flag_r, cfg_r};
	wire tx_busy = (tx_st_r != TX_IDLE);
	wire rx_fe = ~rx & rx_d_r;
	wire rx_tog = rx ^ rx_d_r;
	wire rx_vote_mid = (rx_ovs_r == `SAU_VOTE_DONE);
	wire rx_vote = maj3(rx_smp_r[2], rx_smp_r[1], rx_smp_r[0]);
	wire [8:0] rx_word = len7 ? (par_en ? {rx_sh_r[8], 1'b0, rx_sh_r[7:1]} : {2'b00, rx_sh_r[8:2]})
		: (par_en ? rx_sh_r : {1'b0, rx_sh_r[8:1]});
	wire rx_push = tick_r & (rx_st_r == RX_STOP) & rx_vote_mid;
	wire rd_pop = cs_rise & word_ok & (op == `SAU_OP_RDAT) & r_flag;
	wire wcfg = cs_rise & word_ok & (op == `SAU_OP_WCFG);
	wire wdat = cs_rise & word_ok & (op == `SAU_OP_WDAT);
	wire irq_cond = (cfg_r[`SAU_CFG_RX_DATA_MASK] & r_flag)
		| (cfg_r[`SAU_CFG_TX_DONE_MASK] & t_flag_r)
		| (cfg_r[`SAU_CFG_PARITY_IRQ_MASK] & par_ev_r) | (cfg_r[`SAU_CFG_ACT_MASK] & act_r);

	// ----------------------------------------
	// Host serial port
	// ----------------------------------------
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d_r <= 1'b0;
			cs_d_r <= 1'b1;
			sh_in_r <= 16'h0000;
			sh_out_r <= 16'h0000;
			bcnt_r <= 5'd0;
			dout <= 1'b0;
			dout_oe <= 1'b0;
		end else begin
			sclk_d_r <= sclk;
			cs_d_r <= cs_n;
			dout_oe <= ~cs_n;
			if (cs_n) begin
				bcnt_r <= 5'd0;
			end else if (sclk_rise && bcnt_r != 5'd16) begin
				sh_in_r <= {sh_in_r[14:0], din};
				bcnt_r <= bcnt_r + 5'd1;
				if (bcnt_r == 5'd1) begin
					sh_out_r <= ({sh_in_r[0], din} == `SAU_OP_RCFG) ? {rc_word[13:0], 2'b00}
						: {rd_word[13:0], 2'b00};
				end
			end else if (sclk_fall && bcnt_r >= 5'd1) begin
				dout <= sh_out_r[15];
				sh_out_r <= {sh_out_r[14:0], 1'b0};
			end
			if (cs_d_r & ~cs_n) begin
				dout <= r_flag;
				sh_out_r <= {t_flag_r, 15'h0000};
			end
		end
	end

	// ----------------------------------------
	// Configuration and control
	// ----------------------------------------
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= `SAU_CFG_RESET;
			cfg_pend_r <= `SAU_CFG_RESET;
			cfg_pend_v_r <= 1'b0;
			rts_n <= 1'b1;
			tx_buf_r <= 9'h000;
			tx_buf_v_r <= 1'b0;
			t_flag_r <= 1'b1;
		end else begin
			if (wcfg) begin
				cfg_r[11:8] <= sh_in_r[11:8];
				if (tx_busy) begin
					cfg_pend_r <= sh_in_r[13:0];
					cfg_pend_v_r <= 1'b1;
				end else begin
					cfg_r <= sh_in_r[13:0];
				end
			end else if (cfg_pend_v_r && !tx_busy) begin
				cfg_r <= {cfg_pend_r[13:12], cfg_r[11:8], cfg_pend_r[7:0]};
				cfg_pend_v_r <= 1'b0;
			end
			if (wdat) begin
				rts_n <= ~sh_in_r[`SAU_WD_RTS];
			end
			if (wcfg) begin
				tx_buf_v_r <= 1'b0;
				tx_buf_r <= 9'h000;
				t_flag_r <= 1'b0;
			end else if (wdat && !sh_in_r[`SAU_WD_TE]) begin
				tx_buf_r <= {sh_in_r[`SAU_WD_PARITY], len7 ? 1'b0 : sh_in_r[7], sh_in_r[6:0]};
				tx_buf_v_r <= 1'b1;
				t_flag_r <= 1'b0;
			end else if (tx_buf_v_r && !tx_busy && !pd) begin
				tx_buf_v_r <= 1'b0;
			end else if (tx_done_ev_r) begin
				t_flag_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Baud generator and transmitter
	// ----------------------------------------
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_r <= 16'h0000;
			tick_r <= 1'b0;
			tx_st_r <= TX_IDLE;
			tx_ovs_r <= 4'h0;
			tx_idx_r <= 4'h0;
			tx_sh_r <= 10'h3FF;
			tx <= 1'b1;
			tx_done_ev_r <= 1'b0;
		end else begin
			tx_done_ev_r <= 1'b0;
			if (pd || div_cnt_r >= baud_divisor(cfg_r[3:0]) - 16'h0001) begin
				div_cnt_r <= 16'h0000;
			end else begin
				div_cnt_r <= div_cnt_r + 16'h0001;
			end
			tick_r <= ~pd & (div_cnt_r >= baud_divisor(cfg_r[3:0]) - 16'h0001);
			if (pd) begin
				tx_st_r <= TX_IDLE;
				tx <= 1'b1;
			end else begin
				case (tx_st_r)
					TX_IDLE: begin
						tx <= 1'b1;
						if (tx_buf_v_r && !wcfg) begin
							tx_sh_r <= len7 ? {2'b11, tx_buf_r[8], tx_buf_r[6:0]}
								: {1'b1, tx_buf_r[8], tx_buf_r[7:0]};
							if (!par_en) begin
								tx_sh_r <= len7 ? {3'b111, tx_buf_r[6:0]}
									: {2'b11, tx_buf_r[7:0]};
							end
							tx_st_r <= TX_START;
							tx_ovs_r <= 4'h0;
						end
					end
					TX_START: begin
						if (tick_r) begin
							tx_ovs_r <= tx_ovs_r + 4'h1;
							if (tx_ovs_r == 4'hF) begin
								tx_st_r <= TX_DATA;
								tx_idx_r <= 4'h0;
							end
						end
						tx <= cfg_r[`SAU_CFG_INFRARED] ? (tx_ovs_r >= `SAU_INFRARED_PULSE) : 1'b0;
					end
					TX_DATA: begin
						tx <= cfg_r[`SAU_CFG_INFRARED] ? (tx_sh_r[0] | (tx_ovs_r >= `SAU_INFRARED_PULSE))
							: tx_sh_r[0];
						if (tick_r) begin
							tx_ovs_r <= tx_ovs_r + 4'h1;
							if (tx_ovs_r == 4'hF) begin
								tx_sh_r <= {1'b1, tx_sh_r[9:1]};
								tx_idx_r <= tx_idx_r + 4'h1;
								if (tx_idx_r == nbits - 4'h1) begin
									tx_st_r <= TX_STOP;
								end
							end
						end
					end
					TX_STOP: begin
						tx <= 1'b1;
						if (tick_r) begin
							tx_ovs_r <= tx_ovs_r + 4'h1;
							if (tx_ovs_r == 4'hF) begin
								tx_st_r <= TX_IDLE;
								tx_done_ev_r <= 1'b1;
							end
						end
					end
					default: begin
						tx_st_r <= TX_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Receiver, FIFO and interrupt
	// ----------------------------------------
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rx_d_r <= 1'b1;
			rx_st_r <= RX_IDLE;
			rx_ovs_r <= 4'h0;
			rx_idx_r <= 4'h0;
			rx_smp_r <= 3'b111;
			rx_sh_r <= 9'h000;
			wp_r <= 3'd0;
			rp_r <= 3'd0;
			cnt_r <= 4'd0;
			act_r <= 1'b0;
			par_ev_r <= 1'b0;
			irq_n <= 1'b1;
		end else begin
			rx_d_r <= rx;
			if (tick_r) begin
				rx_ovs_r <= rx_ovs_r + 4'h1;
				// vote over samples 7 to 9
				if (rx_ovs_r >= `SAU_VOTE_A && rx_ovs_r <= `SAU_VOTE_C) begin
					rx_smp_r <= {rx_smp_r[1:0], rx};
				end
			end
			case (rx_st_r)
				RX_IDLE: begin
					if (rx_fe && !pd) begin
						rx_st_r <= RX_BITS;
						rx_ovs_r <= 4'h0;
						rx_idx_r <= 4'hF;
					end
				end
				RX_BITS: begin
					if (tick_r && rx_ovs_r == 4'hF) begin
						rx_idx_r <= rx_idx_r + 4'h1;
						if (rx_idx_r == 4'hF && rx_vote) begin
							rx_st_r <= RX_IDLE;
						end else if (rx_idx_r != 4'hF) begin
							rx_sh_r <= {rx_vote, rx_sh_r[8:1]};
							if (rx_idx_r == nbits - 4'h1) begin
								rx_st_r <= RX_STOP;
							end
						end
					end
				end
				RX_STOP: begin
					if (tick_r && rx_vote_mid) begin
						rx_st_r <= RX_IDLE;
					end
				end
				default: begin
					rx_st_r <= RX_IDLE;
				end
			endcase
			if (pd) begin
				rx_st_r <= RX_IDLE;
			end
			if (wcfg) begin
				wp_r <= 3'd0;
				rp_r <= 3'd0;
				cnt_r <= 4'd0;
			end else if (rx_push && (cnt_r == `SAU_FIFO_DEPTH ||
				(cfg_r[`SAU_CFG_RX_QUEUE_ENABLE_N] && cnt_r != 4'd0 && !rd_pop))) begin
				wp_r <= 3'd0;
				rp_r <= 3'd0;
				cnt_r <= 4'd0;
			end else begin
				if (rx_push) begin
					wp_r <= wp_r + 3'd1;
				end
				if (rd_pop) begin
					rp_r <= rp_r + 3'd1;
				end
				cnt_r <= cnt_r + {3'b000, rx_push} - {3'b000, rd_pop};
			end
			if (wcfg) begin
				act_r <= 1'b0;
			end else if (pd && rx_tog) begin
				act_r <= 1'b1;
			end else if (rd_pop) begin
				act_r <= 1'b0;
			end
			if (rx_push) begin
				par_ev_r <= par_en & rx_sh_r[8];
			end else if (rd_pop || wcfg) begin
				par_ev_r <= 1'b0;
			end
			irq_n <= ~irq_cond;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `SAU_FIFO_DEPTH; gi = gi + 1) begin : g_fifo
			always @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					fifo_r[gi] <= 10'h000;
				end else if (rx_push && wp_r == gi) begin
					fifo_r[gi] <= {~rx_vote, rx_word};
				end
			end
		end
	endgenerate

endmodule // sau_uart

/* File: tb/sau_uart_monitor.sv */
// Port checker for the serial-port UART
`timescale 1ns/10ps
module sau_uart_monitor (
	input wire mclk,
	input wire rst_n,
	input wire hw_powerdown_n,
	input wire sclk,
	input wire cs_n,
	input wire dout,
	input wire dout_oe,
	input wire irq_n,
	input wire tx,
	input wire rts_n,
	input wire rx
);
	reg [1:0] fall_cnt_r;
	reg [1:0] rise_cnt_r;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// ----
	// Cycles since sclk fell and cs_n rose
	// ----
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fall_cnt_r <= 2'h3;
			rise_cnt_r <= 2'h3;
		end else begin
			fall_cnt_r <= $fell(sclk) ? 2'h0 : fall_cnt_r + {1'b0, ~&fall_cnt_r};
			rise_cnt_r <= $rose(cs_n) ? 2'h0 : rise_cnt_r + {1'b0, ~&rise_cnt_r};
		end
	end
	property p_oe_off;
		cs_n [*2] |-> !dout_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("dout driven unselected");
	property p_oe_on;
		$fell(cs_n) |=> dout_oe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("dout not enabled");
	property p_dout_edge;
		dout_oe && $past(dout_oe) && $changed(dout) |-> fall_cnt_r != 2'h3;
	endproperty
	a_dout_edge: assert property (p_dout_edge) else $error("dout moved late");
	property p_dout_hold;
		(!cs_n && sclk) [*2] |-> $stable(dout);
	endproperty
	a_dout_hold: assert property (p_dout_hold) else $error("dout moved on sclk high");
	property p_rts_cs;
		$changed(rts_n) |-> rise_cnt_r != 2'h3;
	endproperty
	a_rts_cs: assert property (p_rts_cs) else $error("rts_n moved off word end");
	property p_rts_hold;
		!cs_n [*3] |-> $stable(rts_n);
	endproperty
	a_rts_hold: assert property (p_rts_hold) else $error("rts_n moved mid word");
	property p_tx_run;
		$changed(tx) |=> ($stable(tx) || !hw_powerdown_n) [*8];
	endproperty
	a_tx_run: assert property (p_tx_run) else $error("tx bit too short");
	property p_pd_tx;
		!hw_powerdown_n [*3] |-> tx;
	endproperty
	a_pd_tx: assert property (p_pd_tx) else $error("tx active in powerdown");
	c_frame: cover property ($fell(tx));
	c_irq: cover property ($fell(irq_n));
	c_pd_rx: cover property (!hw_powerdown_n && $changed(rx));
endmodule // sau_uart_monitor
bind sau_uart sau_uart_monitor u_mon (
	.mclk,
	.rst_n,
	.hw_powerdown_n,
	.sclk,
	.cs_n,
	.dout,
	.dout_oe,
	.irq_n,
	.tx,
	.rts_n,
	.rx
);

/* File: tb/sau_host.sv */
// Host-side serial-port master model
`timescale 1ns/10ps
module sau_host (
	input wire mclk,
	input wire dout,
	output reg sclk,
	output reg cs_n,
	output reg din
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b1;
	end
	task xfer(input [15:0] w, input integer nb, output [15:0] r);
		integer i;
		begin
			r = 16'h0000;
			cs_n <= 1'b0;
			for (i = 15; i >= 16 - nb; i = i - 1) begin
				din <= w[i];
				repeat (4) @(posedge mclk);
				sclk <= 1'b1;
				r[i] = dout;
				repeat (4) @(posedge mclk);
				sclk <= 1'b0;
			end
			repeat (4) @(posedge mclk);
			cs_n <= 1'b1;
			din <= ~din;
			repeat (6) @(posedge mclk);
		end
	endtask
endmodule // sau_host

/* File: tb/tb.sv */
// Self-checking bench for the serial-port UART
`timescale 1ns/10ps
`include "sau_defs.vh"
module tb;
	localparam [13:0] CFG = 14'h0420;
	reg mclk;
	reg rst_n;
	reg hw_powerdown_n;
	reg cts_n;
	reg rx;
	wire sclk, cs_n, din, dout, dout_oe, dline, irq_n, tx, rts_n;
	integer mismatches;
	integer n_compared;
	integer nfr;
	integer n0;
	integer i;
	integer j;
	reg [15:0] rd;
	reg [10:0] frm;
	// Released line shows inverse level
	assign dline = dout_oe ? dout : ~dout;
	always #2.5 mclk = ~mclk;
	sau_uart DUT (
		.mclk,
		.rst_n,
		.hw_powerdown_n,
		.sclk,
		.cs_n,
		.din,
		.dout,
		.dout_oe,
		.irq_n,
		.tx,
		.rts_n,
		.cts_n,
		.rx
	);
	sau_host host (
		.mclk,
		.dout(dline),
		.sclk,
		.cs_n,
		.din
	);
	task chk(input [15:0] got, input [15:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task chk1(input got, input exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask
	task rdchk(input [15:0] w, input [15:0] exp);
		begin
			host.xfer(w, 16, rd);
			chk(rd, exp);
		end
	endtask
	// frames at 16 mclk a bit
	task rxsend(input [10:0] f);
		integer k;
		begin
			for (k = 0; k < 11; k = k + 1) begin
				rx <= f[k];
				repeat (16) @(posedge mclk);
			end
			rx <= 1'b1;
			repeat (8) @(posedge mclk);
		end
	endtask
	task summarize;
		begin
			$display("compared %0d mismatches %0d", n_compared, mismatches);
			if (mismatches == 0 && n_compared > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	always begin
		@(negedge tx);
		repeat (8) @(posedge mclk);
		for (j = 0; j < 11; j = j + 1) begin
			frm[j] = tx;
			repeat (16) @(posedge mclk);
		end
		nfr = nfr + 1;
	end
	initial begin
		repeat (30000) @(posedge mclk);
		mismatches = mismatches + 1;
		summarize;
	end
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		hw_powerdown_n = 1'b1;
		cts_n = 1'b0;
		rx = 1'b1;
		mismatches = 0;
		n_compared = 0;
		nfr = 0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		host.xfer({`SAU_OP_WCFG, 14'h2F5A}, 16, rd);
		rdchk({`SAU_OP_RCFG, 14'h0000}, 16'h2F5A);
		chk1(irq_n, 1'b1);
		host.xfer({`SAU_OP_WCFG, CFG}, 8, rd);
		rdchk({`SAU_OP_RCFG, 14'h0000}, 16'h2F5A);
		host.xfer({`SAU_OP_WCFG, CFG}, 16, rd);
		rdchk({`SAU_OP_RCFG, 14'h0000}, {2'b00, CFG});
		chk1(irq_n, 1'b1);
		n0 = nfr;
		host.xfer(16'h83A5, 16, rd);
		chk1(rts_n, 1'b0);
		for (i = 0; i < 400 && nfr == n0; i = i + 1)
			@(posedge mclk);
		chk({5'h00, frm}, {5'h00, 2'b11, 8'hA5, 1'b0});
		n0 = nfr;
		host.xfer(16'h8400, 16, rd);
		repeat (200) @(posedge mclk);
		chk1(rts_n, 1'b1);
		chk1(nfr == n0, 1'b1);
		rxsend({2'b11, 8'h3C, 1'b0});
		chk1(irq_n, 1'b0);
		rdchk(16'h0000, 16'hC33C);
		chk1(irq_n, 1'b1);
		cts_n <= 1'b1;
		rx <= 1'b0;
		repeat (3) @(posedge mclk);
		rx <= 1'b1;
		repeat (40) @(posedge mclk);
		rdchk(16'h0000, 16'h4000);
		rxsend({2'b00, 8'h55, 1'b0});
		rdchk(16'h0000, 16'hC455);
		for (i = 0; i < `SAU_FIFO_DEPTH; i = i + 1)
			rxsend({2'b11, i[7:0], 1'b0});
		for (i = 0; i < `SAU_FIFO_DEPTH; i = i + 1)
			rdchk(16'h0000, {8'hC1, i[7:0]});
		for (i = 0; i <= `SAU_FIFO_DEPTH; i = i + 1)
			rxsend({2'b11, i[7:0], 1'b0});
		rdchk(16'h0000, 16'h4000);
		rxsend({2'b11, 8'h99, 1'b0});
		host.xfer({`SAU_OP_WCFG, CFG}, 16, rd);
		rdchk(16'h0000, 16'h0000);
		host.xfer({`SAU_OP_WCFG, 14'h0520}, 16, rd);
		host.xfer(16'h8255, 16, rd);
		repeat (40) @(posedge mclk);
		hw_powerdown_n <= 1'b0;
		repeat (4) @(posedge mclk);
		chk1(tx, 1'b1);
		rx <= 1'b0;
		repeat (10) @(posedge mclk);
		chk1(irq_n, 1'b0);
		rdchk(16'h0000, 16'h0400);
		rx <= 1'b1;
		hw_powerdown_n <= 1'b1;
		repeat (200) @(posedge mclk);
		summarize;
	end
endmodule // tb
